/* shared/pev_defines.vh */
`ifndef PEV_DEFINES_VH
`define PEV_DEFINES_VH
// Register addresses
`define PEV_ADDR_ENABLE 8'h00
`define PEV_ADDR_VLEVEL 8'h01
`define PEV_ADDR_FAULT1 8'h02
`define PEV_ADDR_HEALTH 8'h03
// Reset values
`define PEV_RST_ENABLE 8'h00
`define PEV_RST_VLEVEL 8'h00
`define PEV_RST_FAULT1 8'h00
`define PEV_RST_HEALTH 8'h00
// Enable register fields
`define PEV_EN_SCALE 5
`define PEV_EN_CONV1 4
`define PEV_EN_CONV2 3
`define PEV_EN_CONV3 2
`define PEV_USB_SWITCH1_ON_ALT 1
`define PEV_USB_SWITCH2_ON 0
// Level register fields
`define PEV_LV_CONV2_HI 3
`define PEV_LV_CONV2_LO 2
`define PEV_LV_CONV3_HI 1
`define PEV_LV_CONV3_LO 0
// Level field used when scaling is off
`define PEV_LEVEL_NOMINAL 2'h0
// Health register: under-voltage flags and power-good bits
`define PEV_UVD_HI 5
`define PEV_UVD_LO 3
`define PEV_PG_HI 2
`define PEV_PG_LO 0
`endif

/* verilog/pev_flag_bit.v */
`include "pev_defines.vh"
// Sticky flag, cleared on read of its register
module pev_flag_bit (
  input wire i_clk,
  input wire i_resetn,
  input wire i_set,
  input wire i_clr,
  output reg o_flag_q
);
  // Set wins over a read-clear in the same cycle so no event is lost
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_flag_q <= 1'b0;
    end else if (i_set) begin
      o_flag_q <= 1'b1;
    end else if (i_clr) begin
      o_flag_q <= 1'b0;
    end
  end
endmodule // pev_flag_bit

/* verilog/pev_regs.v */
// Behaviour
// - Enable register at 0x00, resets zero, RW
// - Level register at 0x01, resets zero, RW
// - Bit 5 selects scaled levels for converters
// - Bits 4,3,2 enable converters one to three
// - Bits 1,0 switch USB power one, two
// - Converter enable is bit OR pin
// - Converter two level: nominal,-5,-10,-15 percent
// - Converter three level uses same encoding
// - Levels apply only when pin or bit set
// - Fault register 0x02 clears on read; interrupt
// - Health 0x03: under-voltage clears, power-good live
`include "pev_defines.vh"
module pev_regs (
  input wire i_clk,
  input wire i_resetn,
  input wire [7:0] i_addr, // Register address
  input wire i_wr, // One-cycle write strobe
  input wire [7:0] i_wdata, // Write data
  input wire i_rd, // One-cycle read strobe
  output reg [7:0] o_rdata_q, // Read data, valid cycle after i_rd
  input wire [7:0] i_fault_evt, // Fault event pulses, bit per flag
  input wire [2:0] i_uvd_evt, // Under-voltage events, conv1..3
  input wire [2:0] i_pg, // Live power-good, conv1..3
  input wire i_conv1_on_pin, // Dedicated enable pins
  input wire i_conv2_on_pin,
  input wire i_conv3_on_pin,
  input wire i_scaling_select_pin, // Scaling control pin
  output reg o_conv1_on_q,
  output reg o_conv2_on_q,
  output reg o_conv3_on_q,
  output reg o_usb_switch1_on_q,
  output reg o_usb_switch2_on_q,
  output reg [1:0] o_conv2_level_q,
  output reg [1:0] o_conv3_level_q,
  output wire o_int_n_o, // Interrupt pin output value, always low
  output wire o_int_n_oe // Open-drain enable, high while pulling low
);
  ////////////////////////////////////////////////////////////////////
  reg [7:0] enable_q; // Enable control register
  reg [7:0] level_q; // Voltage level select register
  wire [7:0] fault_q; // Sticky fault flags
  wire [2:0] uvd_q; // Sticky under-voltage flags
  wire hit_fault; // Read of fault register
  wire hit_health; // Read of health register
  wire scale_on; // Level fields in force
  assign hit_fault = i_rd && (i_addr == `PEV_ADDR_FAULT1);
  assign hit_health = i_rd && (i_addr == `PEV_ADDR_HEALTH);
  ////////////////////////////////////////////////////////////////////
  // Control register writes; all eight bits store, even unused ones
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      enable_q <= `PEV_RST_ENABLE;
      level_q <= `PEV_RST_VLEVEL;
    end else if (i_wr) begin
      if (i_addr == `PEV_ADDR_ENABLE) begin
        enable_q <= i_wdata;
      end
      if (i_addr == `PEV_ADDR_VLEVEL) begin
        level_q <= i_wdata;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////
  // Flag banks: one instance per sticky bit
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_fault
      pev_flag_bit u_flag (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_set(i_fault_evt[g]),
        .i_clr(hit_fault),
        .o_flag_q(fault_q[g])
      );
    end
    for (g = 0; g < 3; g = g + 1) begin : g_uvd
      pev_flag_bit u_flag (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_set(i_uvd_evt[g]),
        .i_clr(hit_health),
        .o_flag_q(uvd_q[g])
      );
    end
  endgenerate
  ////////////////////////////////////////////////////////////////////
  // Read data register; unmapped addresses read zero
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata_q <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        `PEV_ADDR_ENABLE: o_rdata_q <= enable_q;
        `PEV_ADDR_VLEVEL: o_rdata_q <= level_q;
        `PEV_ADDR_FAULT1: o_rdata_q <= fault_q;
        // Power-good read live, under-voltage from sticky copy
        `PEV_ADDR_HEALTH: o_rdata_q <= {2'b00, uvd_q, i_pg};
        default: o_rdata_q <= 8'h00;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////
  // Interrupt releases once every flag is clear; a read of both status
  // registers clears them, except a flag whose event lands in the read cycle
  assign o_int_n_o = 1'b0;
  assign o_int_n_oe = (|fault_q) | (|uvd_q);
  ////////////////////////////////////////////////////////////////////
  // Effective outputs, registered so analog controls never glitch
  // Pin or bit alone is enough to let the level fields through
  assign scale_on = i_scaling_select_pin |
                    enable_q[`PEV_EN_SCALE];
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_conv1_on_q <= 1'b0;
      o_conv2_on_q <= 1'b0;
      o_conv3_on_q <= 1'b0;
      o_usb_switch1_on_q <= 1'b0;
      o_usb_switch2_on_q <= 1'b0;
      o_conv2_level_q <= `PEV_LEVEL_NOMINAL;
      o_conv3_level_q <= `PEV_LEVEL_NOMINAL;
    end else begin
      o_conv1_on_q <= enable_q[`PEV_EN_CONV1] | i_conv1_on_pin;
      o_conv2_on_q <= enable_q[`PEV_EN_CONV2] | i_conv2_on_pin;
      o_conv3_on_q <= enable_q[`PEV_EN_CONV3] | i_conv3_on_pin;
      o_usb_switch1_on_q <= enable_q[`PEV_USB_SWITCH1_ON_ALT];
      o_usb_switch2_on_q <= enable_q[`PEV_USB_SWITCH2_ON];
      // Code 0 nominal, 1..3 step down by 5 percent each
      if (scale_on) begin
        o_conv2_level_q <=
          level_q[`PEV_LV_CONV2_HI:`PEV_LV_CONV2_LO];
        o_conv3_level_q <=
          level_q[`PEV_LV_CONV3_HI:`PEV_LV_CONV3_LO];
      end else begin
        o_conv2_level_q <= `PEV_LEVEL_NOMINAL;
        o_conv3_level_q <= `PEV_LEVEL_NOMINAL;
      end
    end
  end
endmodule // pev_regs

/* sim/pev_host.sv */
// Host model: holds each request until the next call's edge
module pev_host (
  input wire i_clk,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_wr,
  output logic o_rd
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {o_addr, o_wdata, o_wr, o_rd} = '0;
  // One request per cycle; an idle call releases the bus
  task automatic xfer(input logic w, r, input logic [7:0] a, dt);
    @(posedge i_clk);
    o_wr <= w;
    o_rd <= r;
    o_addr <= a;
    o_wdata <= dt;
  endtask
endmodule // pev_host

/* sim/pev_regs_checker.sv */
module pev_regs_checker (
  input wire i_clk,
  input wire i_resetn,
  input wire [7:0] i_addr,
  input wire i_wr,
  input wire [7:0] i_wdata,
  input wire i_rd,
  input wire [7:0] o_rdata_q,
  input wire [7:0] i_fault_evt,
  input wire [2:0] i_pg,
  input wire i_conv2_on_pin,
  input wire i_scaling_select_pin,
  input wire o_conv1_on_q,
  input wire o_conv2_on_q,
  input wire o_usb_switch1_on_q,
  input wire [1:0] o_conv2_level_q,
  input wire [1:0] o_conv3_level_q,
  input wire o_int_n_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // Enable write followed by a quiet cycle
  sequence s_en_wr;
    i_wr && i_addr == 8'h00 ##1 !i_wr;
  endsequence
  // Level write, then scaling turned on by the enable write
  sequence s_scale;
    i_wr && i_addr == 8'h01 ##1 i_wr && i_addr == 8'h00 && i_wdata[5]
      ##1 !i_wr;
  endsequence
  a_conv1_bit_on: assert property (i_wr && i_addr == 8'h00
    && i_wdata[4] ##1 !i_wr |=> o_conv1_on_q) else $error("conv1 off");
  a_usb1_follows: assert property (s_en_wr |=>
    o_usb_switch1_on_q == $past(i_wdata[1], 2)) else $error("usb1");
  a_conv2_pin_on: assert property (i_conv2_on_pin [*4]
    |-> o_conv2_on_q) else $error("pin enable ignored");
  a_level_nominal: assert property (i_wr && i_addr == 8'h00 &&
    !i_wdata[5] && !i_scaling_select_pin ##1 !i_wr &&
    !i_scaling_select_pin ##1 !i_scaling_select_pin |->
    o_conv2_level_q == 2'h0 && o_conv3_level_q == 2'h0)
    else $error("level not nominal");
  a_level_scaled: assert property (s_scale |=>
    o_conv2_level_q == $past(i_wdata[3:2], 3) &&
    o_conv3_level_q == $past(i_wdata[1:0], 3)) else $error("level");
  a_enable_readback: assert property (i_wr && i_addr == 8'h00
    ##1 i_rd && !i_wr && i_addr == 8'h00 |=>
    o_rdata_q == $past(i_wdata, 2)) else $error("readback");
  a_fault_read_clear: assert property (i_rd && i_addr == 8'h02 &&
    i_fault_evt == 8'h00 ##1 !i_rd && i_fault_evt == 8'h00 ##1 i_rd &&
    i_addr == 8'h02 && i_fault_evt == 8'h00 |=> o_rdata_q == 8'h00)
    else $error("fault flags kept");
  a_pg_live: assert property (i_rd && i_addr == 8'h03 |=>
    o_rdata_q[2:0] == $past(i_pg)) else $error("power good stale");
  a_int_raise: assert property (i_fault_evt != 8'h00 |=>
    o_int_n_oe) else $error("interrupt not driven");
endmodule // pev_regs_checker
bind pev_regs pev_regs_checker i_chk (.i_clk, .i_resetn, .i_addr, .i_wr,
  .i_wdata, .i_rd, .o_rdata_q, .i_fault_evt, .i_pg, .i_conv2_on_pin,
  .i_scaling_select_pin, .o_conv1_on_q, .o_conv2_on_q,
  .o_usb_switch1_on_q, .o_conv2_level_q, .o_conv3_level_q, .o_int_n_oe);

/* sim/pmic_enable_voltage_level_select_regs_tb.sv */
module pmic_enable_voltage_level_select_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rstn = 0, wr, rd, io, ion;
  logic [7:0] a, d, q, fe = 8'h00;
  logic [2:0] ue = 3'h0, pg = 3'h0, pin = 3'h0;
  logic sp = 0;
  logic [8:0] ov;
  int fails = 0, checks = 0, cyc = 0;
  int m[2];
  always #2.5 clk = ~clk;
  pev_host i_host (.i_clk(clk), .o_addr(a), .o_wdata(d), .o_wr(wr),
    .o_rd(rd));
  pev_regs i_dut (.i_clk(clk), .i_resetn(rstn), .i_addr(a), .i_wr(wr),
    .i_wdata(d), .i_rd(rd), .o_rdata_q(q), .i_fault_evt(fe),
    .i_uvd_evt(ue), .i_pg(pg), .i_conv1_on_pin(pin[2]),
    .i_conv2_on_pin(pin[1]), .i_conv3_on_pin(pin[0]),
    .i_scaling_select_pin(sp), .o_conv1_on_q(ov[8]),
    .o_conv2_on_q(ov[7]), .o_conv3_on_q(ov[6]),
    .o_usb_switch1_on_q(ov[5]), .o_usb_switch2_on_q(ov[4]),
    .o_conv2_level_q(ov[3:2]), .o_conv3_level_q(ov[1:0]),
    .o_int_n_o(ion), .o_int_n_oe(io));
  task automatic chk(input logic [8:0] got, exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Read, idle one cycle, then compare the registered data
  task automatic rd_chk(input logic [7:0] ad, exp);
    i_host.xfer(1'b0, 1'b1, ad, 8'h00);
    i_host.xfer(1'b0, 1'b0, ~ad, 8'hff);
    #1 chk({1'b0, q}, {1'b0, exp});
  endtask
  task automatic report_and_stop;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Hang guard: the run needs under two hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      report_and_stop();
    end
  end
  initial begin
    void'($urandom(32'h781bc241));
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    rd_chk(8'h00, 8'h00);
    rd_chk(8'h01, 8'h00);
    rd_chk(8'h07, 8'h00);
    repeat (24) begin
      m[0] = $urandom & 255;
      m[1] = $urandom & 255;
      @(posedge clk);
      pin <= $urandom;
      sp <= $urandom;
      i_host.xfer(1'b1, 1'b0, 8'h01, m[1][7:0]);
      i_host.xfer(1'b1, 1'b0, 8'h00, m[0][7:0]);
      rd_chk(8'h00, m[0][7:0]);
      rd_chk(8'h01, m[1][7:0]);
      chk(ov, {m[0][4:2] | pin, m[0][1:0],
        (sp | m[0][5]) ? m[1][3:0] : 4'h0});
    end
    @(posedge clk);
    fe <= 8'ha5;
    ue <= 3'h5;
    pg <= 3'h3;
    @(posedge clk);
    fe <= 8'h00;
    ue <= 3'h0;
    #1 chk({8'h00, io}, 9'h001);
    chk({8'h00, ion}, 9'h000);
    rd_chk(8'h02, 8'ha5);
    rd_chk(8'h02, 8'h00);
    rd_chk(8'h03, 8'h2b);
    rd_chk(8'h03, 8'h03);
    chk({8'h00, io}, 9'h000);
    report_and_stop();
  end
endmodule // pmic_enable_voltage_level_select_regs_tb
